// [hw/aor_readout.sv]
// Sensor output register readout bank with AXI4-Lite access
//
// Behaviour
// R01 - Status flags at 00h, read only, reset value 01h.
// R02 - Temperature at 01h; burst skips it unless temperature include is set.
// R03 - Magnitude at 02h/03h, split by byte order.
// R04 - Burst skips both magnitude bytes while magnitude enable is 0.
// R05 - X sample at 04h/05h, split by byte order.
// R06 - Y sample at 06h/07h, same split as X.
// R07 - Z sample at 08h/09h, same split as X.
// R08 - Axis skip drops its sample pair and queue pair from bursts; code still goes 0Bh to 10h when X, Y and Z all skip.
// R09 - From 04h: normal goes 05h; fast goes next enabled of 06h/08h/00h.
// R10 - Fast mode: 06h goes 08h or 00h; 08h wraps to 00h.
// R11 - Reserved 0Ah reads 00h; burst continues to 0Bh.
// R12 - Queue status at 0Bh: watermark, overflow, 6-bit count, reset 00h.
// R13 - Queue head X word at 0Ch/0Dh, split like current X.
// R14 - After 0Dh burst goes next enabled of 0Eh, 10h, 0Ch.
// R15 - Fast mode from 0Ch goes next enabled of 0Eh, 10h, 0Ch.
// R16 - From 00h burst goes first enabled of 01h..10h candidates.
// R17 - Byte order, temperature include, fast read are writable setup bits.
// R18 - Per-axis skip bits are writable setup bits.
// R19 - Next burst address is first candidate not excluded by a skip.
// R20 - Both bytes of a 12-bit value come from one snapshot.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module aor_readout #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sample_strobe,
  input wire logic [7:0] temp_in,
  input wire logic [11:0] mag_in,
  input wire logic [11:0] x_in,
  input wire logic [11:0] y_in,
  input wire logic [11:0] z_in,
  input wire logic [11:0] queue_x_in,
  input wire logic status_load,
  input wire logic [7:0] status_in,
  input wire logic queue_load,
  input wire logic queue_watermark,
  input wire logic queue_overflow,
  input wire logic [5:0] queue_count,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SW = aor_pkg::SAMPLE_W;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane;
    logic [7:0] setup_two;
    logic [7:0] setup_five;
    logic [7:0] ptr;
    logic [7:0] status;
    logic [7:0] queue;
    logic [7:0] temp;
    logic [aor_pkg::SNAP_N-1:0][SW-1:0] snap;
    logic hold;
    logic pend;
  } aor_state_t;

  aor_state_t state_reg;
  aor_state_t state_next;
  logic [aor_pkg::SNAP_N-1:0][7:0] lo;
  logic [aor_pkg::SNAP_N-1:0][7:0] hi;
  logic [aor_pkg::SNAP_N-1:0][SW-1:0] live;
  logic order;
  logic fast;
  logic ex;
  logic ey;
  logic ez;
  logic [7:0] en;

  assign live = {queue_x_in, z_in, y_in, x_in, mag_in};
  assign order = state_reg.setup_two[aor_pkg::F_BYTE_ORDER];
  assign fast = state_reg.setup_two[aor_pkg::F_FAST_READ];
  assign ex = ~state_reg.setup_five[aor_pkg::F_X_SKIP];
  assign ey = ~state_reg.setup_five[aor_pkg::F_Y_SKIP];
  assign ez = ~state_reg.setup_five[aor_pkg::F_Z_SKIP];
  // Enables in burst candidate order
  assign en = {ez, ey, ex, ez, ey, ex,
    state_reg.setup_five[aor_pkg::F_MAG_EN],
    state_reg.setup_two[aor_pkg::F_TEMP_INC]}; // R02 R04 R08

  // Byte-order split of each snapshot word
  genvar gi;
  generate
    for (gi = 0; gi < aor_pkg::SNAP_N; gi++) begin : g_split
      aor_split #(.W(SW)) u_split (
        .value(state_reg.snap[gi]),
        .order(order),
        .byte0(lo[gi]),
        .byte1(hi[gi])
      ); // R03 R05 R06 R07 R13
    end
  endgenerate

  // First enabled candidate at or after position from
  function automatic logic [7:0] walk(input logic [2:0] from,
                                      input logic [7:0] mask);
    logic [7:0] r;
    r = aor_pkg::IDX_EVT;
    for (int i = 7; i >= 0; i--) begin
      if (i >= int'(from) && mask[i]) begin
        r = aor_pkg::CHAIN[i];
      end
    end
    return r; // R19
  endfunction

  function automatic logic [7:0] pick3(input logic [7:0] a, input logic ea,
                                       input logic [7:0] b, input logic eb,
                                       input logic [7:0] c);
    return ea ? a : (eb ? b : c); // R19
  endfunction

  // Burst address chain
  function automatic logic [7:0] next_addr(input logic [7:0] p);
    logic [7:0] r;
    logic [7:0] qwrap_x;
    logic [7:0] qwrap_y;
    logic [7:0] qwrap_z;
    logic [7:0] xwrap;
    qwrap_x = pick3(aor_pkg::IDX_QY0, ey, aor_pkg::IDX_QZ0, ez,
                    aor_pkg::IDX_QX0);
    qwrap_y = pick3(aor_pkg::IDX_QZ0, ez, aor_pkg::IDX_QX0, ex,
                    aor_pkg::IDX_QY0);
    qwrap_z = pick3(aor_pkg::IDX_QX0, ex, aor_pkg::IDX_QY0, ey,
                    aor_pkg::IDX_QZ0);
    xwrap = pick3(aor_pkg::IDX_Y0, ey, aor_pkg::IDX_Z0, ez,
                  aor_pkg::IDX_EVT);
    case (p)
      aor_pkg::IDX_EVT: r = walk(aor_pkg::CH_TEMP, en); // R16
      aor_pkg::IDX_TEMP: r = walk(aor_pkg::CH_MAG, en); // R02
      aor_pkg::IDX_MAG0: begin
        r = fast ? walk(aor_pkg::CH_MAG + 3'h1, en) : aor_pkg::IDX_MAG1;
      end
      aor_pkg::IDX_MAG1: r = walk(aor_pkg::CH_MAG + 3'h1, en); // R04
      aor_pkg::IDX_X0: r = fast ? xwrap : aor_pkg::IDX_X1; // R09
      aor_pkg::IDX_X1: r = xwrap; // R08
      aor_pkg::IDX_Y0: begin
        r = fast ? (ez ? aor_pkg::IDX_Z0 : aor_pkg::IDX_EVT)
                 : aor_pkg::IDX_Y1; // R10
      end
      aor_pkg::IDX_Y1: r = ez ? aor_pkg::IDX_Z0 : aor_pkg::IDX_EVT;
      aor_pkg::IDX_Z0: r = fast ? aor_pkg::IDX_EVT : aor_pkg::IDX_Z1; // R10
      aor_pkg::IDX_Z1: r = aor_pkg::IDX_EVT;
      aor_pkg::IDX_RSVD: r = aor_pkg::IDX_QSTAT; // R11
      aor_pkg::IDX_QSTAT: begin
        r = pick3(aor_pkg::IDX_QX0, ex, aor_pkg::IDX_QY0, ey,
                  aor_pkg::IDX_QZ0);
      end
      aor_pkg::IDX_QX0: r = fast ? qwrap_x : aor_pkg::IDX_QX1; // R15
      aor_pkg::IDX_QX1: r = qwrap_x; // R14
      aor_pkg::IDX_QY0: r = fast ? qwrap_y : aor_pkg::IDX_QY1;
      aor_pkg::IDX_QY1: r = qwrap_y;
      aor_pkg::IDX_QZ0: r = fast ? qwrap_z : aor_pkg::IDX_QZ1;
      aor_pkg::IDX_QZ1: r = qwrap_z;
      default: r = p + 8'h01;
    endcase
    return r;
  endfunction

  // Byte held at a bank address
  function automatic logic [7:0] byte_at(input logic [7:0] a);
    logic [7:0] r;
    case (a)
      aor_pkg::IDX_EVT: r = state_reg.status; // R01
      aor_pkg::IDX_TEMP: r = state_reg.temp; // R02
      aor_pkg::IDX_MAG0: r = lo[aor_pkg::S_MAG]; // R03
      aor_pkg::IDX_MAG1: r = hi[aor_pkg::S_MAG];
      aor_pkg::IDX_X0: r = lo[aor_pkg::S_X]; // R05
      aor_pkg::IDX_X1: r = hi[aor_pkg::S_X];
      aor_pkg::IDX_Y0: r = lo[aor_pkg::S_Y]; // R06
      aor_pkg::IDX_Y1: r = hi[aor_pkg::S_Y];
      aor_pkg::IDX_Z0: r = lo[aor_pkg::S_Z]; // R07
      aor_pkg::IDX_Z1: r = hi[aor_pkg::S_Z];
      aor_pkg::IDX_RSVD: r = aor_pkg::RSVD_VAL; // R11
      aor_pkg::IDX_QSTAT: r = state_reg.queue; // R12
      aor_pkg::IDX_QX0: r = lo[aor_pkg::S_QX]; // R13
      aor_pkg::IDX_QX1: r = hi[aor_pkg::S_QX];
      default: r = aor_pkg::RSVD_VAL;
    endcase
    return r;
  endfunction

  function automatic logic first_of_pair(input logic [7:0] a);
    return a == aor_pkg::IDX_MAG0 || a == aor_pkg::IDX_X0 ||
           a == aor_pkg::IDX_Y0 || a == aor_pkg::IDX_Z0 ||
           a == aor_pkg::IDX_QX0;
  endfunction

  always_comb begin
    logic [7:0] ar_idx;
    logic [7:0] eff;
    logic rd_go;
    logic upd;
    ar_idx = s_axi_araddr[9:2];
    eff = ar_idx;
    rd_go = s_axi_arvalid & state_reg.arready;
    upd = 1'b0;
    state_next = state_reg;

    // Write address and data taken in either order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_byte = s_axi_wdata[7:0];
      state_next.w_lane = s_axi_wstrb[0];
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = aor_pkg::RESP_OKAY;
      case (state_reg.aw_idx)
        aor_pkg::IDX_SETUP_TWO: begin
          if (state_reg.w_lane) begin
            state_next.setup_two = state_reg.w_byte &
                                   aor_pkg::SETUP_TWO_MASK; // R17
          end
        end
        aor_pkg::IDX_SETUP_FIVE: begin
          if (state_reg.w_lane) begin
            state_next.setup_five = state_reg.w_byte &
                                    aor_pkg::SETUP_FIVE_MASK; // R18
          end
        end
        aor_pkg::IDX_BURST_PTR: begin
          if (state_reg.w_lane) begin
            state_next.ptr = state_reg.w_byte;
          end
        end
        default: state_next.bresp = aor_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = ~state_next.aw_held & ~state_next.bvalid;
    state_next.wready = ~state_next.w_held & ~state_next.bvalid;

    // Read: answer one cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
    if (rd_go) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = aor_pkg::RESP_OKAY;
      if (ar_idx == aor_pkg::IDX_BURST_DATA) begin
        eff = state_reg.ptr;
        state_next.rdata = 32'(byte_at(state_reg.ptr));
        state_next.ptr = next_addr(state_reg.ptr); // R19
      end else if (ar_idx <= aor_pkg::IDX_QX1) begin
        state_next.rdata = 32'(byte_at(ar_idx));
      end else if (ar_idx == aor_pkg::IDX_SETUP_TWO) begin
        state_next.rdata = 32'(state_reg.setup_two);
      end else if (ar_idx == aor_pkg::IDX_SETUP_FIVE) begin
        state_next.rdata = 32'(state_reg.setup_five);
      end else if (ar_idx == aor_pkg::IDX_BURST_PTR) begin
        state_next.rdata = 32'(state_reg.ptr);
      end else begin
        state_next.rdata = 32'(aor_pkg::RSVD_VAL);
        state_next.rresp = aor_pkg::RESP_SLVERR;
      end
      state_next.hold = first_of_pair(eff); // R20
    end

    // Snapshot refresh deferred while a pair is half read
    upd = (sample_strobe | state_reg.pend) & ~state_next.hold; // R20
    state_next.pend = (sample_strobe | state_reg.pend) & state_next.hold;
    if (upd) begin
      state_next.snap = live;
      state_next.temp = temp_in;
    end
    if (status_load) begin
      state_next.status = status_in; // R01
    end
    if (queue_load) begin
      state_next.queue = aor_pkg::QSTAT_RST;
      state_next.queue[aor_pkg::F_Q_WMARK] = queue_watermark; // R12
      state_next.queue[aor_pkg::F_Q_OVF] = queue_overflow;
      state_next.queue[5:0] = queue_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.setup_two <= aor_pkg::SETUP_RST;
      state_reg.setup_five <= aor_pkg::SETUP_RST;
      state_reg.ptr <= aor_pkg::PTR_RST;
      state_reg.status <= aor_pkg::EVT_RST; // R01
      state_reg.queue <= aor_pkg::QSTAT_RST; // R12
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;
endmodule
`default_nettype wire

// [hw/aor_split.sv]
// Byte-order splitter for one 12-bit value
`timescale 1ns/1ps
`default_nettype none
module aor_split #(
  parameter int W = 12
) (
  input wire logic [W-1:0] value,
  input wire logic order,
  output logic [7:0] byte0,
  output logic [7:0] byte1
);
  localparam int PAD = 16 - W;

  always_comb begin
    if (order) begin
      byte0 = value[W-1:W-8];
      byte1 = {{PAD{1'b0}}, value[W-9:0]};
    end else begin
      byte0 = value[7:0];
      byte1 = {{PAD{1'b0}}, value[W-1:8]};
    end
  end
endmodule
`default_nettype wire

// [pkg/aor_pkg.sv]
// Shared constants for the sensor output register readout bank
package aor_pkg;
  localparam int IDX_W = 8;
  localparam int SNAP_N = 5;
  localparam int SAMPLE_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EVT = 8'h00;
  localparam logic [7:0] IDX_TEMP = 8'h01;
  localparam logic [7:0] IDX_MAG0 = 8'h02;
  localparam logic [7:0] IDX_MAG1 = 8'h03;
  localparam logic [7:0] IDX_X0 = 8'h04;
  localparam logic [7:0] IDX_X1 = 8'h05;
  localparam logic [7:0] IDX_Y0 = 8'h06;
  localparam logic [7:0] IDX_Y1 = 8'h07;
  localparam logic [7:0] IDX_Z0 = 8'h08;
  localparam logic [7:0] IDX_Z1 = 8'h09;
  localparam logic [7:0] IDX_RSVD = 8'h0a;
  localparam logic [7:0] IDX_QSTAT = 8'h0b;
  localparam logic [7:0] IDX_QX0 = 8'h0c;
  localparam logic [7:0] IDX_QX1 = 8'h0d;
  localparam logic [7:0] IDX_QY0 = 8'h0e;
  localparam logic [7:0] IDX_QY1 = 8'h0f;
  localparam logic [7:0] IDX_QZ0 = 8'h10;
  localparam logic [7:0] IDX_QZ1 = 8'h11;
  localparam logic [7:0] IDX_SETUP_TWO = 8'h16;
  localparam logic [7:0] IDX_SETUP_FIVE = 8'h19;
  localparam logic [7:0] IDX_BURST_PTR = 8'h20;
  localparam logic [7:0] IDX_BURST_DATA = 8'h21;
  // Burst candidate order after the status register
  localparam logic [7:0][7:0] CHAIN = {IDX_QZ0, IDX_QY0, IDX_QX0, IDX_Z0,
    IDX_Y0, IDX_X0, IDX_MAG0, IDX_TEMP};
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_MAG = 3'h1;
  // Reset values and the reserved read value
  localparam logic [7:0] EVT_RST = 8'h01;
  localparam logic [7:0] QSTAT_RST = 8'h00;
  localparam logic [7:0] RSVD_VAL = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  // Field positions of sensor_setup_two
  localparam int F_BYTE_ORDER = 0;
  localparam int F_TEMP_INC = 1;
  localparam int F_FAST_READ = 2;
  localparam logic [7:0] SETUP_TWO_MASK = 8'h07;
  // Field positions of sensor_setup_five
  localparam int F_X_SKIP = 0;
  localparam int F_Y_SKIP = 1;
  localparam int F_Z_SKIP = 2;
  localparam int F_MAG_EN = 3;
  localparam logic [7:0] SETUP_FIVE_MASK = 8'h0f;
  // Field positions of sample_queue_status
  localparam int F_Q_WMARK = 7;
  localparam int F_Q_OVF = 6;
  // Snapshot slots
  localparam int S_MAG = 0;
  localparam int S_X = 1;
  localparam int S_Y = 2;
  localparam int S_Z = 3;
  localparam int S_QX = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [sim/aor_host.sv]
// Host model issuing AXI4-Lite register accesses
`timescale 1ns/1ps
`default_nettype none
module aor_host (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/aor_readout_assertions.sv]
// Port checker for the readout bank
`timescale 1ns/1ps
`default_nettype none
module aor_readout_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] wi;
  logic [7:0] ri;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Index of the transfer in flight
  always_ff @(posedge aclk) begin
    if (ce && s_axi_awvalid && s_axi_awready) wi <= s_axi_awaddr[9:2];
    if (ce && s_axi_arvalid && s_axi_arready) ri <= s_axi_araddr[9:2];
  end
  a_read_answer: assert property (
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_release: assert property (
    ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  a_byte_lane: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_write_release: assert property (
    ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not released");
  a_ro_refused: assert property (
    s_axi_bvalid && wi <= aor_pkg::IDX_QX1 |->
    s_axi_bresp == aor_pkg::RESP_SLVERR) else $error("read-only write taken");
  a_setup_okay: assert property (
    s_axi_bvalid && (wi == aor_pkg::IDX_SETUP_TWO ||
    wi == aor_pkg::IDX_SETUP_FIVE) |-> s_axi_bresp == aor_pkg::RESP_OKAY)
    else $error("setup write refused");
  a_reserved_zero: assert property (
    s_axi_rvalid && ri == aor_pkg::IDX_RSVD |-> s_axi_rdata == 32'h0 &&
    s_axi_rresp == aor_pkg::RESP_OKAY) else $error("reserved not zero");
  a_gap_refused: assert property (
    s_axi_rvalid && ri >= aor_pkg::IDX_QY0 && ri <= aor_pkg::IDX_QZ1 |->
    s_axi_rresp == aor_pkg::RESP_SLVERR) else $error("gap read taken");
endmodule
`default_nettype wire

// [sim/tb_accel_output_register_readout.sv]
// Testbench for the readout bank
`timescale 1ns/1ps
`default_nettype none
module tb_accel_output_register_readout;
  localparam logic [1:0] ok = aor_pkg::RESP_OKAY;
  localparam logic [1:0] se = aor_pkg::RESP_SLVERR;
  logic aclk, aresetn, ce, sample_strobe, status_load, queue_load;
  logic [7:0] temp_in, status_in;
  logic [11:0] mag_in, x_in, y_in, z_in, queue_x_in;
  logic queue_watermark, queue_overflow;
  logic [5:0] queue_count;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] ad [5] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0c};
  logic [11:0] va [5] = '{12'habc, 12'h123, 12'h456, 12'h789, 12'h5a6};
  logic [7:0] eb [18] = '{8'ha5, 8'h3c, 8'hbc, 8'h0a, 8'h23, 8'h01, 8'h56,
    8'h04, 8'h89, 8'h07, 8'h00, 8'haa, 8'ha6, 8'h05, 8'h00, 8'h00, 8'h00,
    8'h00};
  aor_readout #(.ADDR_W(12)) DUT (.aclk, .aresetn, .ce, .sample_strobe,
    .temp_in, .mag_in, .x_in, .y_in, .z_in, .queue_x_in, .status_load,
    .status_in, .queue_load, .queue_watermark, .queue_overflow, .queue_count,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  aor_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e,
    input logic [1:0] er);
    logic [7:0] d;
    logic [1:0] r;
    host.rd(i, d, r);
    chk({d, r}, {e, er});
  endtask
  task automatic wrc(input logic [7:0] i, input logic [7:0] d,
    input logic [1:0] er);
    logic [1:0] r;
    host.wr(i, d, r);
    chk({8'h0, r}, {8'h0, er});
  endtask
  task automatic burst(input logic [7:0] s2, input logic [7:0] s5,
    input logic [7:0] a, input logic [3:0][7:0] n);
    wrc(8'h16, s2, ok);
    wrc(8'h19, s5, ok);
    wrc(8'h20, a, ok);
    for (int k = 3; k >= 0; k--) begin
      rdc(8'h21, eb[a], ok);
      rdc(8'h20, n[k], ok);
      a = n[k];
    end
  endtask
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end
  initial begin
    {aresetn, sample_strobe, status_load, queue_load} = 4'h0;
    {queue_watermark, queue_overflow, queue_count} = 8'h00;
    {temp_in, status_in} = 16'h0;
    {mag_in, x_in, y_in, z_in, queue_x_in} = 60'h0;
    ce = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h00, 8'h01, ok);
    rdc(8'h0a, 8'h00, ok);
    rdc(8'h0b, 8'h00, ok);
    rdc(8'h0e, 8'h00, se);
    rdc(8'h3f, 8'h00, se);
    wrc(8'h00, 8'h55, se);
    wrc(8'h0b, 8'h55, se);
    $display("test reset done");
    @(posedge aclk);
    {temp_in, status_in} <= 16'h3ca5;
    {mag_in, x_in, y_in} <= 36'habc123456;
    {z_in, queue_x_in} <= 24'h7895a6;
    {queue_watermark, queue_overflow, queue_count} <= 8'haa;
    {sample_strobe, status_load, queue_load} <= 3'h7;
    @(posedge aclk);
    {sample_strobe, status_load, queue_load} <= 3'h0;
    rdc(8'h00, 8'ha5, ok);
    rdc(8'h01, 8'h3c, ok);
    rdc(8'h0b, 8'haa, ok);
    wrc(8'h16, 8'hff, ok);
    rdc(8'h16, 8'h07, ok);
    wrc(8'h19, 8'hff, ok);
    rdc(8'h19, 8'h0f, ok);
    for (int o = 0; o < 2; o++) begin
      wrc(8'h16, 8'(o), ok);
      for (int k = 0; k < 5; k++) begin
        rdc(ad[k], o ? va[k][11:4] : va[k][7:0], ok);
        rdc(ad[k] + 8'h01, o ? {4'h0, va[k][3:0]} : {4'h0, va[k][11:8]},
          ok);
      end
    end
    $display("test byte order done");
    burst(8'h00, 8'h00, 8'h00, {8'h04, 8'h05, 8'h06, 8'h07});
    burst(8'h02, 8'h08, 8'h00, {8'h01, 8'h02, 8'h03, 8'h04});
    burst(8'h04, 8'h00, 8'h04, {8'h06, 8'h08, 8'h00, 8'h04});
    burst(8'h04, 8'h02, 8'h04, {8'h08, 8'h00, 8'h04, 8'h08});
    burst(8'h00, 8'h01, 8'h09, {8'h00, 8'h06, 8'h07, 8'h08});
    burst(8'h00, 8'h01, 8'h0a, {8'h0b, 8'h0e, 8'h0f, 8'h10});
    burst(8'h00, 8'h06, 8'h0c, {8'h0d, 8'h0c, 8'h0d, 8'h0c});
    burst(8'h04, 8'h04, 8'h0c, {8'h0e, 8'h0c, 8'h0e, 8'h0c});
    $display("test burst chain done");
    wrc(8'h16, 8'h00, ok);
    rdc(8'h04, 8'h23, ok);
    @(posedge aclk);
    x_in <= 12'h0fe;
    sample_strobe <= 1'b1;
    @(posedge aclk);
    sample_strobe <= 1'b0;
    rdc(8'h05, 8'h01, ok);
    rdc(8'h04, 8'hfe, ok);
    ce <= 1'b0;
    x_in <= 12'h777;
    sample_strobe <= 1'b1;
    @(posedge aclk);
    sample_strobe <= 1'b0;
    ce <= 1'b1;
    rdc(8'h05, 8'h00, ok);
    rdc(8'h04, 8'hfe, ok);
    $display("test snapshot done");
    summarize();
  end
endmodule
bind aor_readout aor_readout_chk #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn,
  .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
